// ---- general_timer_reload_capture_map.vh ----
// Register map, field positions and counts of the general-purpose timer block
// Summary of operation
// - Timers three and four may also count low-frequency oscillator / 8 and run in sleep.
// - In 16-bit modes the low-byte clock drives the whole counter.
// - A per-timer field picks capture input: pin, oscillator, comparator 0 or logic unit.
// - 16-bit mode counts each tick, reloads on 0xFFFF rollover, sets high flag.
// - 16-bit interrupts on full overflow, and on low-byte rollover if enabled.
// - In 16-bit reload mode (not split or capture), selected logic-unit output high forces a reload every cycle.
// - Split mode runs two 8-bit auto-reload counters with own reload bytes.
// - In split mode run bit gates only the high counter.
// - In split mode each half picks system clock or external source alone.
// - Split mode high and low byte rollovers set high and low flags.
// - Split interrupts on high overflow, on either byte if low enable set.
// - Overflow flags stay set until software clears them.
// - Capture mode counts freely over the full 16-bit range.
// - Capture mode is active when the capture enable bit is 1.
// - Falling capture edge copies counter into reload and sets high flag.
// - Timer four may count timer three overflows, one step each.
// - Timer four overflow in sleep on oscillator clock raises a wake event.
// - Clock select register bit layout as given, all bits reset to 0.
`ifndef GENERAL_TIMER_RELOAD_CAPTURE_MAP_VH
`define GENERAL_TIMER_RELOAD_CAPTURE_MAP_VH
`define CLKSEL_OFFSET 12'h000
`define TIMER_BASE 4'h1
`define TIMER_LAST 4'h4
`define REG_CTRL0 2'h0
`define REG_CTRL1 2'h1
`define REG_COUNT 2'h2
`define REG_RELOAD 2'h3
`define CLKSEL_RESET 8'h00
`define CTRL0_RESET 6'h00
`define CTRL1_RESET 7'h00
`define C0_HFLAG 7
`define C0_LFLAG 6
`define C0_LEN 5
`define C0_CAPEN 4
`define C0_SPLIT 3
`define C0_RUN 2
`define C1_IEN 4
`define C1_LOSYS 5
`define C1_HISYS 6
`define CK_T3H 7
`define CK_T3L 6
`define CK_T2H 5
`define CK_T2L 4
`define XCLK_PRESC 2'h0
`define XCLK_PIN8 2'h1
`define XCLK_LFO8 2'h2
`define XCLK_CHAIN 2'h3
`define CAP_PIN 2'h0
`define CAP_LFO 2'h1
`define CAP_CMP0 2'h2
`define CAP_CLU 2'h3
`define PRESC_DIV0 6'd12
`define PRESC_DIV1 6'd4
`define PRESC_DIV2 6'd48
`define PRESC_DIV3 6'd8
`endif

// ---- general_timer_reload_capture.v ----
// Four 16-bit reload/split/capture timers with an APB register slave
//
// The APB slave port and the register offsets were chosen for this implementation.
`include "general_timer_reload_capture_map.vh"
module general_timer_reload_capture #(
    parameter EXT_DIV = 8
) (
    input wire I_CLK, // System clock, 200 MHz
    input wire I_NRST, // Asynchronous reset, active low
    input wire I_PSEL, // APB select
    input wire I_PENABLE, // APB enable
    input wire I_PWRITE, // APB direction, high for write
    input wire [11:0] I_PADDR, // APB byte address
    input wire [31:0] I_PWDATA, // APB write data
    output reg [31:0] O_PRDATA, // APB read data
    output reg O_PREADY, // APB ready
    output reg O_PSLVERR, // APB error on unmapped address
    input wire [3:0] I_CAP_PIN, // Capture pins, one per timer
    input wire [3:0] I_EXT_CLK, // External count clocks, one per timer
    input wire I_LFO, // Low-frequency oscillator clock as a signal
    input wire I_CMP0, // Comparator 0 output
    input wire [3:0] I_CLU_OUT, // Logic-unit synchronous outputs
    input wire I_LOW_POWER, // High while device is in suspend or snooze
    output reg [3:0] O_IRQ, // Timer interrupt requests, level
    output reg O_WAKE // Wake pulse from timer four
);

localparam [31:0] EXT_DIV_W = EXT_DIV;
localparam [2:0] EXT_TOP = EXT_DIV_W[2:0] - 3'd1;

reg [7:0] clksel_reg;
reg [5:0] ctrl0_reg [0:3];
reg [6:0] ctrl1_reg [0:3];
reg [15:0] count_reg [0:3];
reg [15:0] reload_reg [0:3];
reg [3:0] hflag_reg;
reg [3:0] lflag_reg;
reg [3:0] cap_prev_reg;
reg [9:0] sync1_reg;
reg [9:0] sync2_reg;
reg [9:0] sync3_reg;
reg [2:0] pin_div_reg [0:3];
reg [2:0] lfo_div_reg;
reg [5:0] presc_reg;
reg t3_ovf_reg;

reg [15:0] count_next [0:3];
reg [15:0] reload_next [0:3];
reg [3:0] hflag_next;
reg [3:0] lflag_next;
reg [3:0] cap_next;
reg [3:0] ovf;
reg [3:0] pin_tick;
reg lfo_tick;
reg presc_tick;
reg [31:0] rdata;
reg rd_err;

wire wr_en = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
wire [3:0] tsel = I_PADDR[7:4] - `TIMER_BASE;
wire t_hit = (I_PADDR[11:8] == 4'h0) && (I_PADDR[7:4] >= `TIMER_BASE) &&
             (I_PADDR[7:4] <= `TIMER_LAST) && (I_PADDR[1:0] == 2'h0);
wire ck_hit = (I_PADDR == `CLKSEL_OFFSET);
wire [1:0] rsel = I_PADDR[3:2];

function [5:0] presc_div;
    input [1:0] s;
    begin
        case (s)
            2'h0: presc_div = `PRESC_DIV0;
            2'h1: presc_div = `PRESC_DIV1;
            2'h2: presc_div = `PRESC_DIV2;
            default: presc_div = `PRESC_DIV3;
        endcase
    end
endfunction

// Synchronised capture pins, ext clocks, oscillator, comparator
wire [3:0] pin_s = sync2_reg[3:0];
wire [3:0] ext_s = sync2_reg[7:4];
wire [3:0] ext_d = sync3_reg[7:4];
wire lfo_s = sync2_reg[8];
wire lfo_d = sync3_reg[8];
wire cmp_s = sync2_reg[9];

// Dividers feeding the external clock choices
always @* begin
    presc_tick = (presc_reg == presc_div(clksel_reg[1:0]) - 6'd1);
    lfo_tick = lfo_d & ~lfo_s & (lfo_div_reg == EXT_TOP);
    pin_tick = 4'h0;
    if (ext_d[0] & ~ext_s[0] & (pin_div_reg[0] == EXT_TOP)) begin
        pin_tick[0] = 1'b1;
    end
    if (ext_d[1] & ~ext_s[1] & (pin_div_reg[1] == EXT_TOP)) begin
        pin_tick[1] = 1'b1;
    end
    if (ext_d[2] & ~ext_s[2] & (pin_div_reg[2] == EXT_TOP)) begin
        pin_tick[2] = 1'b1;
    end
    if (ext_d[3] & ~ext_s[3] & (pin_div_reg[3] == EXT_TOP)) begin
        pin_tick[3] = 1'b1;
    end
end

// Counting, reload, capture and flag logic per timer
integer n;
reg ext_tick;
reg lo_tick;
reg hi_tick;
reg cap_in;
reg hset;
reg lset;
reg [15:0] cnt_hw;
reg [15:0] rld_hw;
reg [1:0] xclk;
reg [1:0] frs;
always @* begin
    ovf = 4'h0;
    hflag_next = hflag_reg;
    lflag_next = lflag_reg;
    cap_next = cap_prev_reg;
    ext_tick = 1'b0;
    lo_tick = 1'b0;
    hi_tick = 1'b0;
    cap_in = 1'b0;
    hset = 1'b0;
    lset = 1'b0;
    cnt_hw = 16'h0000;
    rld_hw = 16'h0000;
    xclk = 2'h0;
    frs = 2'h0;
    for (n = 0; n < 4; n = n + 1) begin
        cnt_hw = count_reg[n];
        rld_hw = reload_reg[n];
        hset = 1'b0;
        lset = 1'b0;
        xclk = ctrl0_reg[n][1:0];
        frs = ctrl1_reg[n][3:2];
        case (xclk)
            `XCLK_PRESC: ext_tick = presc_tick;
            `XCLK_PIN8: ext_tick = pin_tick[n];
            `XCLK_LFO8: ext_tick = lfo_tick & ((n == 1) || (n == 2));
            default: ext_tick = t3_ovf_reg & (n == 2);
        endcase
        if (n == 0) begin
            lo_tick = clksel_reg[`CK_T2L] | ext_tick;
            hi_tick = clksel_reg[`CK_T2H] | ext_tick;
        end else if (n == 1) begin
            lo_tick = clksel_reg[`CK_T3L] | ext_tick;
            hi_tick = clksel_reg[`CK_T3H] | ext_tick;
        end else begin
            lo_tick = ctrl1_reg[n][`C1_LOSYS] | ext_tick;
            hi_tick = ctrl1_reg[n][`C1_HISYS] | ext_tick;
        end
        case (ctrl1_reg[n][1:0])
            `CAP_PIN: cap_in = pin_s[n];
            `CAP_LFO: cap_in = lfo_s;
            `CAP_CMP0: cap_in = cmp_s;
            default: cap_in = I_CLU_OUT[n];
        endcase
        cap_next[n] = cap_in;
        if (ctrl0_reg[n][`C0_SPLIT] && !ctrl0_reg[n][`C0_CAPEN]) begin
            if (lo_tick) begin
                if (count_reg[n][7:0] == 8'hff) begin
                    cnt_hw[7:0] = reload_reg[n][7:0];
                    lset = 1'b1;
                end else begin
                    cnt_hw[7:0] = count_reg[n][7:0] + 8'h01;
                end
            end
            if (hi_tick && ctrl0_reg[n][`C0_RUN]) begin
                if (count_reg[n][15:8] == 8'hff) begin
                    cnt_hw[15:8] = reload_reg[n][15:8];
                    hset = 1'b1;
                    ovf[n] = 1'b1;
                end else begin
                    cnt_hw[15:8] = count_reg[n][15:8] + 8'h01;
                end
            end
        end else begin
            if (lo_tick && ctrl0_reg[n][`C0_RUN]) begin
                if (count_reg[n] == 16'hffff) begin
                    cnt_hw = ctrl0_reg[n][`C0_CAPEN] ? 16'h0000 : reload_reg[n];
                    hset = 1'b1;
                    lset = 1'b1;
                    ovf[n] = 1'b1;
                end else begin
                    cnt_hw = count_reg[n] + 16'h0001;
                    lset = (count_reg[n][7:0] == 8'hff);
                end
            end
            if (!ctrl0_reg[n][`C0_CAPEN] && (frs != 2'h0) && I_CLU_OUT[frs - 2'h1]) begin
                cnt_hw = reload_reg[n];
            end
            if (ctrl0_reg[n][`C0_CAPEN] && cap_prev_reg[n] && !cap_in) begin
                rld_hw = count_reg[n];
                hset = 1'b1;
            end
        end
        count_next[n] = cnt_hw;
        reload_next[n] = rld_hw;
        if (wr_en && t_hit && (tsel == n)) begin
            if (rsel == `REG_CTRL0) begin
                hflag_next[n] = I_PWDATA[`C0_HFLAG];
                lflag_next[n] = I_PWDATA[`C0_LFLAG];
            end else if (rsel == `REG_COUNT) begin
                count_next[n] = I_PWDATA[15:0];
            end else if (rsel == `REG_RELOAD) begin
                reload_next[n] = I_PWDATA[15:0];
            end
        end
        // Hardware set wins over a same-cycle software clear
        hflag_next[n] = hflag_next[n] | hset;
        lflag_next[n] = lflag_next[n] | lset;
    end
end

// Read data decode, sampled in the setup phase
always @* begin
    rdata = 32'h0000_0000;
    rd_err = 1'b0;
    if (ck_hit) begin
        rdata = {24'h000000, clksel_reg};
    end else if (t_hit && (rsel == `REG_CTRL0)) begin
        rdata = {24'h000000, hflag_reg[tsel[1:0]], lflag_reg[tsel[1:0]], ctrl0_reg[tsel[1:0]]};
    end else if (t_hit && (rsel == `REG_CTRL1)) begin
        rdata = {25'h0000000, ctrl1_reg[tsel[1:0]]};
    end else if (t_hit && (rsel == `REG_COUNT)) begin
        rdata = {16'h0000, count_reg[tsel[1:0]]};
    end else if (t_hit) begin
        rdata = {16'h0000, reload_reg[tsel[1:0]]};
    end else begin
        rd_err = 1'b1;
    end
end

wire t4_lfo = (ctrl0_reg[2][1:0] == `XCLK_LFO8) ||
              ((ctrl0_reg[2][1:0] == `XCLK_CHAIN) && (ctrl0_reg[1][1:0] == `XCLK_LFO8) &&
               !clksel_reg[`CK_T3L]);

integer k;
always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
        clksel_reg <= `CLKSEL_RESET;
        hflag_reg <= 4'h0;
        lflag_reg <= 4'h0;
        cap_prev_reg <= 4'hf;
        sync1_reg <= 10'h000;
        sync2_reg <= 10'h000;
        sync3_reg <= 10'h000;
        lfo_div_reg <= 3'h0;
        presc_reg <= 6'h00;
        t3_ovf_reg <= 1'b0;
        O_PRDATA <= 32'h0000_0000;
        O_PREADY <= 1'b0;
        O_PSLVERR <= 1'b0;
        O_IRQ <= 4'h0;
        O_WAKE <= 1'b0;
        for (k = 0; k < 4; k = k + 1) begin
            ctrl0_reg[k] <= `CTRL0_RESET;
            ctrl1_reg[k] <= `CTRL1_RESET;
            count_reg[k] <= 16'h0000;
            reload_reg[k] <= 16'h0000;
            pin_div_reg[k] <= 3'h0;
        end
    end else begin
        sync1_reg <= {I_CMP0, I_LFO, I_EXT_CLK, I_CAP_PIN};
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
        presc_reg <= presc_tick ? 6'h00 : presc_reg + 6'h01;
        if (lfo_d & ~lfo_s) begin
            lfo_div_reg <= (lfo_div_reg == EXT_TOP) ? 3'h0 : lfo_div_reg + 3'h1;
        end
        hflag_reg <= hflag_next;
        lflag_reg <= lflag_next;
        cap_prev_reg <= cap_next;
        t3_ovf_reg <= ovf[1];
        O_WAKE <= I_LOW_POWER & ovf[2] & t4_lfo & ~ctrl1_reg[2][`C1_LOSYS];
        for (k = 0; k < 4; k = k + 1) begin
            count_reg[k] <= count_next[k];
            reload_reg[k] <= reload_next[k];
            if (ext_d[k] & ~ext_s[k]) begin
                pin_div_reg[k] <= (pin_div_reg[k] == EXT_TOP) ? 3'h0 : pin_div_reg[k] + 3'h1;
            end
            O_IRQ[k] <= ctrl1_reg[k][`C1_IEN] &
                        (hflag_next[k] | (ctrl0_reg[k][`C0_LEN] & lflag_next[k]));
        end
        // APB: ready one cycle after setup, registered read data
        O_PREADY <= I_PSEL & ~I_PENABLE;
        if (I_PSEL & ~I_PENABLE) begin
            O_PRDATA <= I_PWRITE ? 32'h0000_0000 : rdata;
            O_PSLVERR <= rd_err;
        end
        if (wr_en && ck_hit) begin
            clksel_reg <= I_PWDATA[7:0];
        end else if (wr_en && t_hit && (rsel == `REG_CTRL0)) begin
            ctrl0_reg[tsel[1:0]] <= I_PWDATA[5:0];
        end else if (wr_en && t_hit && (rsel == `REG_CTRL1)) begin
            ctrl1_reg[tsel[1:0]] <= I_PWDATA[6:0];
        end
    end
end

endmodule // general_timer_reload_capture

// ---- general_timer_reload_capture_checker.sv ----
// Bus and output timing checks for the timer block
module general_timer_reload_capture_checker (
    input wire I_CLK, // Clock
    input wire I_NRST, // Reset
    input wire I_PSEL, // Select
    input wire I_PENABLE, // Enable
    input wire I_PWRITE, // Direction
    input wire [11:0] I_PADDR, // Address
    input wire [31:0] I_PWDATA, // Write data
    input wire [31:0] O_PRDATA, // Read data
    input wire O_PREADY, // Ready
    input wire O_PSLVERR, // Error
    input wire I_LOW_POWER, // Sleep
    input wire [3:0] O_IRQ, // Interrupts
    input wire O_WAKE // Wake pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    wire setup = I_PSEL && !I_PENABLE;
    wire wr_done = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
    reg [7:0] sel_reg;
    // Shadow of the clock select register
    always @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) sel_reg <= 8'h00;
        else if (wr_done && I_PADDR == 12'h000) sel_reg <= I_PWDATA[7:0];
    end
    ready_after_setup_a: assert property (setup |=> O_PREADY) else $error("ready missing");
    ready_in_access_a: assert property (O_PREADY |-> I_PSEL && I_PENABLE) else $error("stray ready");
    ready_one_cycle_a: assert property (O_PREADY |=> !O_PREADY) else $error("ready too long");
    unmapped_error_a: assert property (setup && I_PADDR == 12'h008 |=> O_PSLVERR && O_PRDATA == 32'h0)
        else $error("unmapped not refused");
    clock_select_read_a: assert property (setup && !I_PWRITE && I_PADDR == 12'h000 |=>
        !O_PSLVERR && O_PRDATA == {24'h000000, sel_reg}) else $error("clock select wrong");
    wake_in_sleep_a: assert property (O_WAKE |-> $past(I_LOW_POWER)) else $error("wake while awake");
    wake_single_a: assert property (O_WAKE |=> !O_WAKE) else $error("wake too long");
    irq_disable_a: assert property (wr_done && I_PADDR == 12'h014 && !I_PWDATA[4] |=> ##1 !O_IRQ[0])
        else $error("irq stays on");
    cover property (O_WAKE);
    cover property (O_PSLVERR && O_PREADY);
    cover property ($rose(O_IRQ[0]));
endmodule // general_timer_reload_capture_checker
bind general_timer_reload_capture general_timer_reload_capture_checker i_general_timer_reload_capture_checker (
    .I_CLK(I_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
    .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .I_LOW_POWER(I_LOW_POWER), .O_IRQ(O_IRQ), .O_WAKE(O_WAKE));

// ---- general_timer_reload_capture_bench.sv ----
// Self-checking bench for the timer block
module general_timer_reload_capture_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, wake;
    logic lfo = 1'b1, cmp0 = 1'b1, lp = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] cap = 4'hf, configurable_logic_unit = 4'h0, irq, ext = 4'h0;
    int n_fail = 0, n_tests = 0, n_wake = 0;
    always #2.5 clk = ~clk;
    general_timer_reload_capture i_general_timer_reload_capture (
        .I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_CAP_PIN(cap), .I_EXT_CLK(ext), .I_LFO(lfo), .I_CMP0(cmp0), .I_CLU_OUT(configurable_logic_unit),
        .I_LOW_POWER(lp), .O_IRQ(irq), .O_WAKE(wake));
    always @(posedge clk) if (wake === 1'b1) n_wake++;
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        check(n, e, rd & m);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic set_src(input int s, input logic v);
        case (s)
            0: cap[0] <= v;
            1: lfo <= v;
            2: cmp0 <= v;
            default: configurable_logic_unit[0] <= v;
        endcase
    endtask
    task automatic lfo_falls(input int n);
        repeat (n) begin
            lfo <= 1'b0;
            idle(4);
            lfo <= 1'b1;
            idle(4);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        final_report();
    end
    initial begin
        idle(20);
        nrst <= 1'b1;
        idle(1);
        rdc("clock select reset", 12'h000, 32'h0, 32'hffffffff);
        wr(12'h000, 32'hff);
        rdc("clock select bits", 12'h000, 32'hff, 32'hffffffff);
        apb(1'b0, 12'h008, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        // 16-bit reload, only the low-byte clock on system clock
        wr(12'h000, 32'h10);
        wr(12'h01c, 32'h1234);
        wr(12'h018, 32'hfffe);
        wr(12'h014, 32'h10);
        wr(12'h010, 32'h04);
        idle(4);
        rdc("overflow flags", 12'h010, 32'hc4, 32'hff);
        check("interrupt level", 32'h1, {31'h0, irq[0]});
        rdc("count reloaded", 12'h018, 32'h1200, 32'hff00);
        idle(20);
        rdc("flag kept", 12'h010, 32'h80, 32'h80);
        wr(12'h010, 32'h0);
        rdc("flag cleared", 12'h010, 32'h0, 32'hc0);
        // Timer five: pin clock, forced reload, low interrupt, capture wrap
        wr(12'h040, 32'h09);
        repeat (16) begin
            ext[3] <= 1'b1;
            idle(4);
            ext[3] <= 1'b0;
            idle(4);
        end
        idle(4);
        rdc("pin divided count", 12'h048, 32'h2, 32'hffff);
        wr(12'h040, 32'h0);
        wr(12'h04c, 32'h0abc);
        wr(12'h044, 32'h04);
        configurable_logic_unit[0] <= 1'b1;
        idle(2);
        configurable_logic_unit[0] <= 1'b0;
        rdc("forced reload", 12'h048, 32'h0abc, 32'hffff);
        wr(12'h044, 32'h30);
        wr(12'h048, 32'h00fe);
        wr(12'h040, 32'h28);
        idle(4);
        check("low byte interrupt", 32'h1, {31'h0, irq[3]});
        rdc("low flag only", 12'h040, 32'h68, 32'hff);
        wr(12'h040, 32'h08);
        idle(2);
        check("low interrupt masked", 32'h0, {31'h0, irq[3]});
        wr(12'h040, 32'h0);
        wr(12'h048, 32'hfffe);
        wr(12'h040, 32'h14);
        idle(2);
        rdc("capture wraps to zero", 12'h048, 32'h0, 32'hff00);
        rdc("wrap flags", 12'h040, 32'hd4, 32'hff);
        wr(12'h040, 32'h0);
        // Split mode: low half runs with run bit clear
        wr(12'h000, 32'h30);
        wr(12'h01c, 32'h2050);
        wr(12'h018, 32'h10fe);
        wr(12'h010, 32'h08);
        idle(4);
        rdc("split low flag", 12'h010, 32'h48, 32'hc8);
        rdc("high held", 12'h018, 32'h1000, 32'hff00);
        wr(12'h018, 32'hff00);
        wr(12'h010, 32'h0c);
        idle(2);
        rdc("split high flag", 12'h010, 32'h80, 32'h80);
        rdc("high reloaded", 12'h018, 32'h2000, 32'hf000);
        wr(12'h000, 32'h10);
        for (int s = 0; s < 4; s++) begin
            idle(1);
            set_src(s, 1'b1);
            wr(12'h014, 32'(s));
            wr(12'h010, 32'h14);
            set_src((s + 1) % 4, 1'b0);
            idle(6);
            rdc("other source", 12'h010, 32'h0, 32'h80);
            set_src(s, 1'b0);
            idle(6);
            rdc("capture flag", 12'h010, 32'h80, 32'h80);
            set_src((s + 1) % 4, 1'b1);
        end
        wr(12'h010, 32'h0);
        // Timer four counts timer three overflows, both on the oscillator
        wr(12'h028, 32'hffff);
        wr(12'h02c, 32'hffff);
        wr(12'h038, 32'hffff);
        wr(12'h03c, 32'hffff);
        wr(12'h030, 32'h07);
        wr(12'h020, 32'h06);
        lfo_falls(16);
        idle(8);
        check("wake while awake", 32'h0, n_wake);
        lp <= 1'b1;
        lfo_falls(40);
        idle(8);
        check("wake count", 32'h5, n_wake);
        final_report();
    end
endmodule // general_timer_reload_capture_bench
